// [bench/adg_host_model.sv]
/* Host side of the serial register port: sends frames, collects replies.
   Assumes one caller at a time; serial clock idles high between frames. */
`timescale 1ns/100ps
module adg_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    // Released select, idle clock
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // n bits MSB first; five clocks a half period keeps the design's sampler happy
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            repeat (5) @(negedge clk);
            sclk = 1'b0;
            din  = w[i];
            repeat (5) @(negedge clk);
            sclk = 1'b1;
            r    = {r[14:0], dout};
        end
        repeat (5) @(negedge clk);
        cs_n = 1'b1;
        din  = ~din; // Stale data must not look valid
        repeat (4) @(negedge clk);
    endtask
endmodule

// [bench/adg_status_alarm_assertions.sv]
/* Port checker for the alarm and diagnostic block.
   Assumes it is bound onto adg_status_alarm and sees its ports only. */
`timescale 1ns/100ps
module adg_status_alarm_assertions (
    // Clock, reset and serial port
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    // Samples and indicator lines
    input wire logic sample_tick,
    input wire logic first_digital_io_line_o,
    input wire logic first_digital_io_line_oe,
    input wire logic second_digital_io_line_o,
    input wire logic second_digital_io_line_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Indicator level on whichever line is enabled
    wire logic [1:0] oe = {second_digital_io_line_oe, first_digital_io_line_oe};
    wire logic       iv = first_digital_io_line_oe ? first_digital_io_line_o : second_digital_io_line_o;
    a_one_line: assert property (!(&oe))
        else $error("both lines enabled");
    a_oe_from_reset: assert property ($past(rst) |-> oe == 2'b00)
        else $error("line enabled out of reset");
    a_oe_by_write: assert property ($changed(oe) |-> !$past(cs_n, 4) || !$past(cs_n, 5))
        else $error("line enable moved without a frame");
    a_oe_settles: assert property ($changed(oe) |=> $stable(oe) [*2])
        else $error("line enable moved twice");
    a_val_cause: assert property (|oe && $stable(oe) && $changed(iv) |->
        $past(sample_tick, 3) || $past(sample_tick, 4) || !$past(cs_n, 4) || !$past(cs_n, 5))
        else $error("indicator moved without tick or frame");
    a_idle_stable: assert property ((cs_n && !sample_tick) [*7] |-> $stable(iv) && $stable(oe))
        else $error("indicator moved while idle");
    a_dout_enable: assert property (dout_oe == !cs_n)
        else $error("data out enable wrong");
    a_dout_hold: assert property (!cs_n && !$past(cs_n, 2) && $changed(dout) |-> !sclk)
        else $error("data out moved off the falling serial edge");
endmodule
bind adg_status_alarm adg_status_alarm_assertions chk_u (.clk, .rst, .sclk, .cs_n, .dout, .dout_oe, .sample_tick,
    .first_digital_io_line_o, .first_digital_io_line_oe, .second_digital_io_line_o, .second_digital_io_line_oe);

// [bench/adg_status_alarm_tb_top.sv]
/* Bench for the alarm and diagnostic block, driven through serial frames.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/100ps
module adg_status_alarm_tb_top import adg_pkg::*; ;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         sample_tick = 1'b0;
    adg_srcs_t    raw_srcs = '0;
    adg_srcs_t    filt_srcs = '0;
    adg_diag_ev_t diag_ev = '0;
    logic         sclk, cs_n, din, dout, f_o, f_oe, s_o, s_oe;
    logic [15:0]  r;
    logic [15:0]  msk [5] = '{16'hBFFF, 16'hBFFF, 16'h00FF, 16'h00FF, 16'hFF17};
    int           err_count = 0;
    int           cmp_count = 0;
    initial begin
        forever #50 clk = ~clk;
    end
    adg_host_model host_u (.clk, .sclk, .cs_n, .din, .dout);
    adg_status_alarm dut_u (.clk, .rst, .sclk, .cs_n, .din, .dout, .dout_oe(), .sample_tick, .raw_srcs, .filt_srcs,
        .diag_ev, .first_digital_io_line_o(f_o), .first_digital_io_line_oe(f_oe), .second_digital_io_line_o(s_o),
        .second_digital_io_line_oe(s_oe));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Byte writes low then high; a read answers in the following frame
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        host_u.frame({2'b10, a, v[7:0]}, 16, r);
        host_u.frame({2'b10, a | 6'h01, v[15:8]}, 16, r);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        host_u.frame({2'b00, a, 8'h00}, 16, r);
        host_u.frame(16'h0000, 16, r);
        chk(r, e);
    endtask
    task automatic tk();
        sample_tick = 1'b1;
        @(negedge clk);
        sample_tick = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    // Registers, flags, static, filtered and rate alarms in turn
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd(6'h10, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            rd(6'h20 + 6'(2 * i), 16'h0000);
            wr(6'h20 + 6'(2 * i), 16'hFFFF);
            rd(6'h20 + 6'(2 * i), msk[i]);
            wr(6'h20 + 6'(2 * i), 16'h0000);
        end
        diag_ev = adg_diag_ev_t'(8'hBF);
        @(negedge clk);
        diag_ev = adg_diag_ev_t'(8'hA0);
        tk();
        host_u.frame(16'h0000, 8, r);
        rd(6'h3C, 16'h007E);
        diag_ev = adg_diag_ev_t'(8'h60);
        tk();
        rd(6'h3C, 16'h0011);
        tk();
        diag_ev = '0;
        repeat (3) @(negedge clk);
        rd(6'h3C, 16'h0010);
        raw_srcs.gyro = 14'd100;
        wr(6'h20, 16'h8032);
        wr(6'h28, 16'h0206);
        tk();
        chk({13'h0, f_oe, f_o, s_oe}, 16'h0006);
        rd(6'h3C, 16'h0100);
        raw_srcs.gyro = 14'h3F9C;
        tk();
        rd(6'h3C, 16'h0000);
        raw_srcs.gyro = 14'd100;
        wr(6'h28, 16'h0205);
        tk();
        chk({13'h0, s_oe, s_o, f_oe}, 16'h0004);
        wr(6'h28, 16'h6010);
        chk({14'h0, f_oe, s_oe}, 16'h0000);
        wr(6'h22, 16'h0014);
        raw_srcs.temp = 14'd1000;
        filt_srcs.temp = 14'd5;
        rd(6'h3C, 16'h0100);
        tk();
        rd(6'h3C, 16'h0200);
        wr(6'h28, 16'h6000);
        tk();
        rd(6'h3C, 16'h0000);
        wr(6'h24, 16'h0002);
        wr(6'h20, 16'h800A);
        wr(6'h28, 16'h0D00);
        repeat (4) tk();
        rd(6'h3C, 16'h0000);
        raw_srcs.aux = 14'd20;
        tk();
        rd(6'h3C, 16'h0100);
        tk();
        rd(6'h3C, 16'h0100);
        tk();
        rd(6'h3C, 16'h0000);
        end_of_test();
    end
endmodule

// [core/adg_alarm_eval.sv]
/*
 * One alarm comparator: static level or rate of change against a threshold.
 * Assumes sample ticks are at least two clocks apart so old_smp is settled.
 */
`timescale 1ns/100ps
`include "adg_defines.svh"
module adg_alarm_eval
    import adg_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Configuration
    input  wire logic                   en,
    input  wire logic                   rate,
    input  wire logic                   is_signed,
    input  wire logic                   pol_gt,
    input  wire logic [`ADG_DATA_W-1:0] thr,
    input  wire logic [7:0]             depth,
    // Samples
    input  wire logic                   tick,
    input  wire logic [`ADG_DATA_W-1:0] cur_smp,
    input  wire logic [`ADG_DATA_W-1:0] old_smp,
    // Result, one pulse per evaluated tick
    output logic                        hit_vld,
    output logic                        hit
);

    adg_eval_st_t           st_ff;
    adg_eval_st_t           nxt_st;
    logic signed [15:0]     cur_x;
    logic signed [15:0]     old_x;
    logic signed [15:0]     thr_x;
    logic signed [15:0]     diff;
    logic signed [15:0]     mag;
    logic signed [15:0]     val;
    logic                   cond;

    ////////////////////////////////////////////////////////////////////////
    // Widen to a common signed form; threshold follows source format
    always_comb begin
        cur_x = is_signed ? 16'($signed(cur_smp)) : {2'h0, cur_smp};
        old_x = is_signed ? 16'($signed(old_smp)) : {2'h0, old_smp};
        thr_x = is_signed ? 16'($signed(thr)) : {2'h0, thr};
        diff  = cur_x - old_x;
        mag   = diff[15] ? -diff : diff;
        thr_x = rate ? {2'h0, thr} : thr_x;                              // Change size is unsigned
        val   = rate ? mag : cur_x;
        cond  = pol_gt ? (val > thr_x) : (val < thr_x);
    end

    ////////////////////////////////////////////////////////////////////////
    // Count stored samples so a rate result needs a full window
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.hit_vld = 1'b0;
        if (!en) begin
            nxt_st.fill = 8'h00;
            nxt_st.hit  = 1'b0;
        end else if (tick) begin
            nxt_st.hit_vld = 1'b1;
            nxt_st.hit     = rate ? (cond && st_ff.fill >= depth) : cond;
            if (st_ff.fill != 8'hFF) begin
                nxt_st.fill = st_ff.fill + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hit_vld = st_ff.hit_vld;
    assign hit     = st_ff.hit;

endmodule

// [core/adg_defines.svh]
/*
 * Constants for the alarm and diagnostic status block: register offsets,
 * field positions, write masks, reset values and serial frame figures.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef ADG_DEFINES_SVH
`define ADG_DEFINES_SVH

// Register offsets (byte addresses in the 6-bit serial address space)
`define ADG_OFS_THR1        6'h20
`define ADG_OFS_THR2        6'h22
`define ADG_OFS_SMPL1       6'h24
`define ADG_OFS_SMPL2       6'h26
`define ADG_OFS_CTRL        6'h28
`define ADG_OFS_DIAG        6'h3C

// Reset value shared by all configuration registers
`define ADG_CFG_RST         16'h0000

// Writable bits; unused bits read as zero
`define ADG_THR_MASK        16'hBFFF
`define ADG_SMPL_MASK       16'h00FF
`define ADG_CTRL_MASK       16'hFF17
`define ADG_DIAG_MASK       16'h037F

// Diagnostic flag positions
`define ADG_DG_ALM2         9
`define ADG_DG_ALM1         8
`define ADG_DG_CHKSUM       6
`define ADG_DG_SELFTEST     5
`define ADG_DG_OVERRANGE    4
`define ADG_DG_SPI          3
`define ADG_DG_FLASH        2
`define ADG_DG_SUP_HIGH     1
`define ADG_DG_SUP_LOW      0

// Threshold fields
`define ADG_THR_POL         15
`define ADG_THR_MSB         13

// Alarm control fields
`define ADG_CT_RATE2        15
`define ADG_CT_SRC2_LSB     12
`define ADG_CT_RATE1        11
`define ADG_CT_SRC1_LSB     8
`define ADG_CT_FILT         4
`define ADG_CT_OUT_EN       2
`define ADG_CT_OUT_POL      1
`define ADG_CT_OUT_SEL      0

// Source selection codes
`define ADG_SRC_OFF         3'h0
`define ADG_SRC_SUPPLY      3'h1
`define ADG_SRC_GYRO        3'h2
`define ADG_SRC_AUX         3'h5
`define ADG_SRC_TEMP        3'h6

// Serial frame: write flag, bit count; sample width and history depth
`define ADG_SPI_WR_BIT      15
`define ADG_SPI_BITS        5'h10
`define ADG_DATA_W          14
`define ADG_HIST_DEPTH      256

`endif

// [core/adg_hist_mem.sv]
/*
 * Sample history memory for one alarm channel: one write port,
 * one read port whose data come out of a register.
 * Assumes writes and the address of interest change only on sample ticks.
 */
`timescale 1ns/100ps
module adg_hist_mem
    import adg_pkg::*;
#(
    parameter int W     = 14,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } adg_mem_st_t;

    adg_mem_st_t st_ff;
    adg_mem_st_t nxt_st;

    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("adg_hist_mem: DEPTH must be 2**AW");
    end

    ////////////////////////////////////////////////////////////////////////
    // Write then registered read
    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.mem[wr_addr] = wr_data;
        end
        nxt_st.rd = st_ff.mem[rd_addr];
    end

    // Cleared history keeps early rate results defined
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rd;

endmodule

// [core/adg_pkg.sv]
/*
 * Types of the alarm and diagnostic status block.
 * Assumes adg_defines.svh is on the include path.
 */
package adg_pkg;
`include "adg_defines.svh"

    // One word per selectable alarm source
    typedef struct packed {
        logic [`ADG_DATA_W-1:0] supply;
        logic [`ADG_DATA_W-1:0] gyro;
        logic [`ADG_DATA_W-1:0] aux;
        logic [`ADG_DATA_W-1:0] temp;
    } adg_srcs_t;

    // Diagnostic events from the rest of the sensor
    typedef struct packed {
        logic supply_high;
        logic supply_low;
        logic overrange;
        logic chk_done;
        logic chk_fail;
        logic st_done;
        logic st_fail;
        logic flash_fail;
    } adg_diag_ev_t;

    // Whole state of the top block
    typedef struct packed {
        logic [1:0][15:0] thr;
        logic [1:0][15:0] smpl;
        logic [15:0]      ctrl;
        logic [15:0]      diag;
        logic             sclk_q;
        logic             cs_q;
        logic [15:0]      rx;
        logic [15:0]      tx;
        logic [4:0]       cnt;
        logic [7:0]       wp;
        logic [1:0]       dio_val;
        logic [1:0]       dio_oe;
    } adg_top_st_t;

    // Whole state of one alarm evaluator
    typedef struct packed {
        logic [7:0] fill;
        logic       hit_vld;
        logic       hit;
    } adg_eval_st_t;

endpackage

// [core/adg_status_alarm.sv]
/*
 * Alarm and diagnostic status block: serial register access, diagnostic
 * flags, two alarm channels and the alarm indicator on the digital lines.
 * Assumes all inputs are synchronous to clk, sample_tick is a one-clock
 * pulse per internal sample, and serial clock runs far below clk.
 */
// Behaviour
// - Alarm 2 status in flag bit 9, alarm 1 in bit 8.
// - Bit 6 set on checksum compare fail, cleared on pass.
// - Bit 5 set when automatic self-test fails, left clear on pass.
// - Bits 4, 3, 2: overrange, serial failure, flash update failure.
// - Bit 1 high while supply high, bit 0 high while supply low.
// - Two independent alarms, each with own threshold, count, source, mode.
// - Threshold bit 15 chooses greater-than or less-than; bit 14 unused.
// - Threshold bits 13:0 follow the selected source's number format in static mode, unsigned in rate mode.
// - Rate window equals programmed sample count times sample period.
// - Sample count from low byte; 0 and 1 both mean one sample.
// - Alarm 2 rate mode by control bit 15, else static level.
// - Alarm 2 source from control bits 14:12; 000 disables it.
// - Alarm 1 mode by control bit 11, source by bits 10:8.
// - Control bit 4 selects filtered or unfiltered comparison data.
// - Indicator driven only when bit 2 set; bit 1 selects level.
// - Control bit 0 routes indicator to second or first line.
// - Threshold, count and control registers reset to zero.
// - Reading the flag register clears all flags.
// - A persisting condition sets its flag again next sample.
// - Supply flags clear by themselves once supply is back in range.
`timescale 1ns/100ps
`include "adg_defines.svh"
module adg_status_alarm
    import adg_pkg::*;
#(
    parameter int DATA_W     = 14,
    parameter int HIST_DEPTH = 256
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Serial register port
    input  wire logic         sclk,
    input  wire logic         cs_n,
    input  wire logic         din,
    output logic              dout,
    output logic              dout_oe,
    // Sample stream
    input  wire logic         sample_tick,
    input  wire adg_srcs_t    raw_srcs,
    input  wire adg_srcs_t    filt_srcs,
    // Diagnostic events
    input  wire adg_diag_ev_t diag_ev,
    // Digital lines
    output logic              first_digital_io_line_o,
    output logic              first_digital_io_line_oe,
    output logic              second_digital_io_line_o,
    output logic              second_digital_io_line_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (DATA_W != `ADG_DATA_W || HIST_DEPTH != `ADG_HIST_DEPTH) begin : g_bad_param
        $error("adg_status_alarm: DATA_W must be 14 and HIST_DEPTH 256");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    adg_top_st_t              st_ff;
    adg_top_st_t              nxt_st;
    logic                     sclk_rise;
    logic                     sclk_fall;
    logic                     frame_start;
    logic                     frame_end;
    logic                     frame_ok;
    logic                     wr_hit;
    logic                     rd_hit;
    logic [5:0]               addr;
    logic                     hi_byte;
    logic [7:0]               wr_data;
    logic                     diag_read;
    adg_srcs_t                srcs;
    logic [1:0][2:0]          src_code;
    logic [1:0]               rate_mode;
    logic [1:0]               ch_en;
    logic [1:0]               ch_signed;
    logic [1:0][DATA_W-1:0]   ch_smp;
    logic [1:0][DATA_W-1:0]   ch_old;
    logic [1:0][7:0]          ch_depth;
    logic [1:0][7:0]          rd_addr;
    logic [1:0]               hit_vld;
    logic [1:0]               hit;
    logic                     alarm_any;
    logic                     ind_level;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Merge one written byte into a register, then drop unused bits
    function automatic logic [15:0] merge_byte(input logic [15:0] old_val,
                                               input logic        upper,
                                               input logic [7:0]  data,
                                               input logic [15:0] mask);
        logic [15:0] res;
        res = upper ? {data, old_val[7:0]} : {old_val[15:8], data};
        return res & mask;
    endfunction

    // Register read map; unmapped addresses read zero
    function automatic logic [15:0] read_word(input adg_top_st_t s, input logic [5:0] a);
        logic [15:0] res;
        res = 16'h0000;
        unique case (a)
            `ADG_OFS_THR1:  res = s.thr[0];
            `ADG_OFS_THR2:  res = s.thr[1];
            `ADG_OFS_SMPL1: res = s.smpl[0];
            `ADG_OFS_SMPL2: res = s.smpl[1];
            `ADG_OFS_CTRL:  res = s.ctrl;
            `ADG_OFS_DIAG:  res = s.diag;
            default:        res = 16'h0000;
        endcase
        return res;
    endfunction

    // Pick a source word and tell whether its format is signed
    function automatic logic [DATA_W:0] pick_src(input adg_srcs_t s, input logic [2:0] code);
        logic [DATA_W:0] res;
        res = '0;
        unique case (code)
            `ADG_SRC_SUPPLY: res = {1'b0, s.supply};
            `ADG_SRC_GYRO:   res = {1'b1, s.gyro};
            `ADG_SRC_AUX:    res = {1'b0, s.aux};
            `ADG_SRC_TEMP:   res = {1'b1, s.temp};
            default:         res = '0;
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial frame decoding; inputs arrive already synchronous
    assign sclk_rise   = ~cs_n & sclk & ~st_ff.sclk_q;
    assign sclk_fall   = ~cs_n & ~sclk & st_ff.sclk_q;
    assign frame_start = st_ff.cs_q & ~cs_n;
    assign frame_end   = ~st_ff.cs_q & cs_n;
    assign frame_ok    = frame_end && (st_ff.cnt == `ADG_SPI_BITS);
    assign wr_hit      = frame_ok & st_ff.rx[`ADG_SPI_WR_BIT];
    assign rd_hit      = frame_ok & ~st_ff.rx[`ADG_SPI_WR_BIT];
    assign addr        = {st_ff.rx[13:9], 1'b0};
    assign hi_byte     = st_ff.rx[8];
    assign wr_data     = st_ff.rx[7:0];
    assign diag_read   = rd_hit && (addr == `ADG_OFS_DIAG);

    // Serial data out; driven only inside a frame
    assign dout    = st_ff.tx[15];
    assign dout_oe = ~cs_n;

    ////////////////////////////////////////////////////////////////////////
    // Alarm source selection per channel
    assign srcs         = st_ff.ctrl[`ADG_CT_FILT] ? filt_srcs : raw_srcs;
    assign src_code[0]  = st_ff.ctrl[`ADG_CT_SRC1_LSB +: 3];
    assign src_code[1]  = st_ff.ctrl[`ADG_CT_SRC2_LSB +: 3];
    assign rate_mode[0] = st_ff.ctrl[`ADG_CT_RATE1];
    assign rate_mode[1] = st_ff.ctrl[`ADG_CT_RATE2];

    ////////////////////////////////////////////////////////////////////////
    // Two alarm channels; unused source codes also leave a channel idle
    for (genvar ch = 0; ch < 2; ch++) begin : g_alarm
        logic [DATA_W:0] picked;

        // Source word with format flag
        assign picked        = pick_src(srcs, src_code[ch]);
        assign ch_smp[ch]    = picked[DATA_W-1:0];
        assign ch_signed[ch] = picked[DATA_W];
        assign ch_en[ch]     = (src_code[ch] == `ADG_SRC_SUPPLY) || (src_code[ch] == `ADG_SRC_GYRO) ||
                               (src_code[ch] == `ADG_SRC_AUX) || (src_code[ch] == `ADG_SRC_TEMP);

        // Zero and one both give a one-sample window
        assign ch_depth[ch]  = (st_ff.smpl[ch][7:1] == 7'h00) ? 8'h01 : st_ff.smpl[ch][7:0];
        assign rd_addr[ch]   = st_ff.wp - ch_depth[ch];

        adg_hist_mem #(
            .W      (DATA_W),
            .DEPTH  (HIST_DEPTH),
            .AW     (8)
        ) u_hist (
            .clk     (clk),
            .rst     (rst),
            .wr_en   (sample_tick),
            .wr_addr (st_ff.wp),
            .wr_data (ch_smp[ch]),
            .rd_addr (rd_addr[ch]),
            .rd_data (ch_old[ch])
        );

        adg_alarm_eval u_eval (
            .clk       (clk),
            .rst       (rst),
            .en        (ch_en[ch]),
            .rate      (rate_mode[ch]),
            .is_signed (ch_signed[ch]),
            .pol_gt    (st_ff.thr[ch][`ADG_THR_POL]),
            .thr       (st_ff.thr[ch][`ADG_THR_MSB:0]),
            .depth     (ch_depth[ch]),
            .tick      (sample_tick),
            .cur_smp   (ch_smp[ch]),
            .old_smp   (ch_old[ch]),
            .hit_vld   (hit_vld[ch]),
            .hit       (hit[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator level from the alarm flags
    assign alarm_any = st_ff.diag[`ADG_DG_ALM2] | st_ff.diag[`ADG_DG_ALM1];
    assign ind_level = st_ff.ctrl[`ADG_CT_OUT_POL] ? alarm_any : ~alarm_any;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.sclk_q = sclk;
        nxt_st.cs_q   = cs_n;

        // Receive shifter and bit counter
        if (frame_start || frame_end) begin
            nxt_st.cnt = 5'h00;
        end else if (sclk_rise) begin
            nxt_st.rx = {st_ff.rx[14:0], din};
            if (st_ff.cnt != 5'h1F) begin
                nxt_st.cnt = st_ff.cnt + 5'h01;
            end
        end

        // Transmit word loads at end of a read frame, shifts on falling edges
        if (frame_end) begin
            nxt_st.tx = rd_hit ? read_word(st_ff, addr) : 16'h0000;
        end else if (sclk_fall && st_ff.cnt != 5'h00) begin
            nxt_st.tx = {st_ff.tx[14:0], 1'b0};
        end

        // Register writes, one byte per frame
        if (wr_hit) begin
            unique case (addr)
                `ADG_OFS_THR1:  nxt_st.thr[0]  = merge_byte(st_ff.thr[0], hi_byte, wr_data, `ADG_THR_MASK);
                `ADG_OFS_THR2:  nxt_st.thr[1]  = merge_byte(st_ff.thr[1], hi_byte, wr_data, `ADG_THR_MASK);
                `ADG_OFS_SMPL1: nxt_st.smpl[0] = merge_byte(st_ff.smpl[0], hi_byte, wr_data, `ADG_SMPL_MASK);
                `ADG_OFS_SMPL2: nxt_st.smpl[1] = merge_byte(st_ff.smpl[1], hi_byte, wr_data, `ADG_SMPL_MASK);
                `ADG_OFS_CTRL:  nxt_st.ctrl    = merge_byte(st_ff.ctrl, hi_byte, wr_data, `ADG_CTRL_MASK);
                default:        nxt_st.ctrl    = st_ff.ctrl;                 // Unmapped or read-only: ignored
            endcase
        end

        // History pointer advances once per sample
        if (sample_tick) begin
            nxt_st.wp = st_ff.wp + 8'h01;
        end

        // Flags: the read clears first so a same-cycle event still sets
        if (diag_read) begin
            nxt_st.diag = 16'h0000;
        end
        for (int ch = 0; ch < 2; ch++) begin
            if (hit_vld[ch] && hit[ch]) begin
                nxt_st.diag[`ADG_DG_ALM1 + ch] = 1'b1;
            end
        end
        if (diag_ev.chk_done) begin
            nxt_st.diag[`ADG_DG_CHKSUM] = diag_ev.chk_fail;
        end
        if (diag_ev.st_done && diag_ev.st_fail) begin
            nxt_st.diag[`ADG_DG_SELFTEST] = 1'b1;
        end
        if (sample_tick && diag_ev.overrange) begin
            nxt_st.diag[`ADG_DG_OVERRANGE] = 1'b1;
        end
        if (frame_end && st_ff.cnt != 5'h00 && st_ff.cnt != `ADG_SPI_BITS) begin
            nxt_st.diag[`ADG_DG_SPI] = 1'b1;
        end
        if (diag_ev.flash_fail) begin
            nxt_st.diag[`ADG_DG_FLASH] = 1'b1;
        end

        // Supply flags follow the level, falling at once when back in range
        nxt_st.diag[`ADG_DG_SUP_HIGH] = diag_ev.supply_high &
            (sample_tick | nxt_st.diag[`ADG_DG_SUP_HIGH]);
        nxt_st.diag[`ADG_DG_SUP_LOW]  = diag_ev.supply_low &
            (sample_tick | nxt_st.diag[`ADG_DG_SUP_LOW]);
        nxt_st.diag = nxt_st.diag & `ADG_DIAG_MASK;

        // Indicator routing to one of the two digital lines
        nxt_st.dio_val = {2{ind_level}};
        nxt_st.dio_oe  = 2'h0;
        if (st_ff.ctrl[`ADG_CT_OUT_EN]) begin
            nxt_st.dio_oe[st_ff.ctrl[`ADG_CT_OUT_SEL]] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; configuration comes up all zero, alarms disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff        <= '0;
            st_ff.thr    <= {2{`ADG_CFG_RST}};
            st_ff.smpl   <= {2{`ADG_CFG_RST}};
            st_ff.ctrl   <= `ADG_CFG_RST;
            st_ff.sclk_q <= 1'b1;
            st_ff.cs_q   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital line outputs, all from flip-flops
    assign first_digital_io_line_o   = st_ff.dio_val[0];
    assign first_digital_io_line_oe  = st_ff.dio_oe[0];
    assign second_digital_io_line_o  = st_ff.dio_val[1];
    assign second_digital_io_line_oe = st_ff.dio_oe[1];

endmodule
